// *** bitm_params.svh ***
`ifndef BITM_PARAMS_SVH
`define BITM_PARAMS_SVH

// Register indices, byte address is four times the index
`define BITM_IDX_CTRL       16'h7F0E
`define BITM_IDX_SRC        16'h7F0F
`define BITM_IDX_STAT       16'h7F10
`define BITM_IDX_MASK       16'h7F11

// Reset values
`define BITM_RST_CTRL       8'h00
`define BITM_RST_SRC        1'b0
`define BITM_RST_STAT       2'h0
`define BITM_RST_MASK       2'h0

// Control register field positions
`define BITM_B_FAST         7
`define BITM_B_RUN          6
`define BITM_B_CODE_HI      5
`define BITM_B_CODE_LO      4
`define BITM_B_INTERVAL1_FLAG         3
`define BITM_B_IE1          2
`define BITM_B_INTERVAL0_FLAG         1
`define BITM_B_IE0          0

// Status and mask bit positions
`define BITM_S_INT0         0
`define BITM_S_INT1         1

// Interval widths in counter bits (period = 2**width base clock periods)
`define BITM_W_INT1_C00     5'd5
`define BITM_W_INT1_C01     5'd7
`define BITM_W_INT1_C10     5'd9
`define BITM_W_INT1_C11     5'd11
`define BITM_W_INT0_SLOW    5'd14
`define BITM_W_INT0_F00     5'd6
`define BITM_W_INT0_F01     5'd6
`define BITM_W_INT0_F1X     5'd16
`define BITM_W_WDT_SLOW     5'd13
`define BITM_W_WDT_FAST     5'd5

// System clock divider ratio for the divided base source
`define BITM_SYS_DIV        8'd4

// AXI responses
`define BITM_RESP_OKAY      2'h0
`define BITM_RESP_DECERR    2'h3

`endif

// *** bitm_pkg.sv ***
package bitm_pkg;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       fast;       // Fast period select
        logic       run;        // Continuous counting
        logic [1:0] code;       // Period code
        logic       interval1_flag;       // Interval 1 flag
        logic       ie1;        // Interval 1 enable
        logic       interval0_flag;       // Interval 0 flag
        logic       ie0;        // Interval 0 enable
    } bitm_ctrl_type;

    // Base input clock source
    typedef enum logic {
        BITM_SRC_OSC    = 1'b0,
        BITM_SRC_SYSDIV = 1'b1
    } bitm_src_type;

    // Interval events of one base tick
    typedef struct packed {
        logic int1;             // Interval 1 elapsed
        logic int0;             // Interval 0 elapsed
        logic wdt;              // Watchdog clock edge
    } bitm_evt_type;

endpackage

// *** bitm_base_clk.sv ***
`timescale 1ns/1ps
`include "bitm_params.svh"

module bitm_base_clk
    import bitm_pkg::*;
#(
    parameter logic [7:0] SYS_DIV = `BITM_SYS_DIV
) (
    input  wire logic         sys_clk_i,    // System clock
    input  wire logic         rst_i,        // Async reset, high
    input  wire logic         osc_i,        // First oscillator pin
    input  wire bitm_src_type src_i,        // Source select
    output logic              tick_o        // One base period pulse
);

    logic       osc_s1_q;                   // Sync stage one
    logic       osc_s2_q;                   // Sync stage two
    logic       osc_s3_q;                   // Edge history
    logic [7:0] div_q;                      // System clock divider

    // Oscillator pin passes two flops before use
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // Free running divider, wraps at the ratio
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
        end else if (div_q >= SYS_DIV - 8'h01) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // base clock source
    // Oscillator must be slower than half the system clock to be seen
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else if (src_i == BITM_SRC_OSC) begin
            tick_o <= osc_s2_q & ~osc_s3_q;
        end else begin
            tick_o <= (div_q == 8'h00);
        end
    end

endmodule

// *** bitm_timer.sv ***
`timescale 1ns/1ps
`include "bitm_params.svh"

// Contract
// - sixteen-bit up-counter, eight interval choices
// - low byte counts base, cascades upward
// - high byte counts base or carry
// - base clock is oscillator or divided
// - run clear halts at zero count
// - fast clear gives 16384 and 8192
// - code sets interval one 32..2048
// - fast set follows code for interval0
// - watchdog clock 32 or 8192 periods
// - interval one flag sticky until written
// - interval zero flag sticky until written
// - enable one with flag requests interrupt
// - enable zero with flag requests interrupt
module bitm_timer
    import bitm_pkg::*;
#(
    parameter int         AW      = 18,             // AXI address width
    parameter logic [7:0] SYS_DIV = `BITM_SYS_DIV   // Divided source ratio
) (
    input  wire logic          sys_clk_i,           // 20 MHz clock
    input  wire logic          rst_i,               // Async reset, high
    input  wire logic          osc_i,               // First oscillator pin
    input  wire logic [AW-1:0] s_axi_awaddr,        // Write address
    input  wire logic          s_axi_awvalid,       // Write address valid
    output logic               s_axi_awready,       // Write address ready
    input  wire logic [31:0]   s_axi_wdata,         // Write data
    input  wire logic [3:0]    s_axi_wstrb,         // Write strobes
    input  wire logic          s_axi_wvalid,        // Write data valid
    output logic               s_axi_wready,        // Write data ready
    output logic [1:0]         s_axi_bresp,         // Write response
    output logic               s_axi_bvalid,        // Write response valid
    input  wire logic          s_axi_bready,        // Write response ready
    input  wire logic [AW-1:0] s_axi_araddr,        // Read address
    input  wire logic          s_axi_arvalid,       // Read address valid
    output logic               s_axi_arready,       // Read address ready
    output logic [31:0]        s_axi_rdata,         // Read data
    output logic [1:0]         s_axi_rresp,         // Read response
    output logic               s_axi_rvalid,        // Read data valid
    input  wire logic          s_axi_rready,        // Read data ready
    output logic               irq_o,               // Masked status interrupt
    output logic               vec_irq_o,           // Interval interrupt request
    output logic               hold_release_o,      // Deep hold release
    output logic               wdt_tick_o           // Watchdog clock pulse
);

    bitm_ctrl_type   ctrl_q;                        // Control register
    bitm_src_type    src_q;                         // Base source select
    logic [1:0]      stat_q;                        // Sticky event status
    logic [1:0]      mask_q;                        // Interrupt mask
    logic [7:0]      lo_q;                          // Low counter byte
    logic [7:0]      hi_q;                          // High counter byte
    logic            tick;                          // Base period pulse
    logic            adv;                           // Counter advances now
    logic            direct;                        // High byte counts base
    logic [15:0]     cnt;                           // Full count value
    bitm_evt_type    evt;                           // Events of this tick
    logic [AW-1:0]   awaddr_q;                      // Held write address
    logic            aw_have_q;                     // Write address held
    logic [31:0]     wdata_q;                       // Held write data
    logic [3:0]      wstrb_q;                       // Held write strobes
    logic            w_have_q;                      // Write data held
    logic            wr_go;                         // Perform write now
    logic            wr_ctrl;                       // Write hits control
    logic            wr_src;                        // Write hits source
    logic            wr_stat;                       // Write hits status
    logic            wr_mask;                       // Write hits mask
    logic [7:0]      wbyte;                         // Written low byte

    // Byte address of a register index
    function automatic logic [AW-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = AW'({idx, 2'b00});
    endfunction

    // True when the lowest w bits of v are all ones
    function automatic logic low_ones(input logic [15:0] v, input logic [4:0] w);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if ((5'(i) < w) && !v[i]) begin
                r = 1'b0;
            end
        end
        low_ones = r;
    endfunction

    // Decoder of mapped addresses, word aligned
    function automatic logic is_mapped(input logic [AW-1:0] a);
        is_mapped = (a == reg_addr(`BITM_IDX_CTRL)) || (a == reg_addr(`BITM_IDX_SRC))
                 || (a == reg_addr(`BITM_IDX_STAT)) || (a == reg_addr(`BITM_IDX_MASK));
    endfunction

    bitm_base_clk #(
        .SYS_DIV (SYS_DIV)
    ) u_base_clk (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .osc_i     (osc_i),
        .src_i     (src_q),
        .tick_o    (tick)
    );

    assign cnt = {hi_q, lo_q};

    // high byte takes base directly in short fast modes
    assign direct = ctrl_q.fast & ~ctrl_q.code[1];

    // halt once count is zero with run clear
    assign adv = tick & (ctrl_q.run | (cnt != 16'h0000));

    // Interval events decoded from count about to roll
    always_comb begin
        evt = '0;
        if (adv) begin
            // interval one follows period code only
            case (ctrl_q.code)
                2'b00:   evt.int1 = low_ones(cnt, `BITM_W_INT1_C00);
                2'b01:   evt.int1 = low_ones(cnt, `BITM_W_INT1_C01);
                2'b10:   evt.int1 = low_ones(cnt, `BITM_W_INT1_C10);
                default: evt.int1 = low_ones(cnt, `BITM_W_INT1_C11);
            endcase
            if (!ctrl_q.fast) begin
                evt.int0 = low_ones(cnt, `BITM_W_INT0_SLOW);
                evt.wdt  = low_ones(cnt, `BITM_W_WDT_SLOW);
            end else begin
                // fast setting, interval zero by code
                case (ctrl_q.code)
                    2'b00:   evt.int0 = low_ones({8'h00, hi_q}, `BITM_W_INT0_F00);
                    2'b01:   evt.int0 = low_ones({8'h00, hi_q}, `BITM_W_INT0_F01);
                    default: evt.int0 = low_ones(cnt, `BITM_W_INT0_F1X);
                endcase
                evt.wdt = direct ? low_ones({8'h00, hi_q}, `BITM_W_WDT_FAST)
                                 : low_ones(cnt, `BITM_W_WDT_SLOW);
            end
        end
    end

    // low byte counts base, high byte counts carry or, when direct, base
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else if (adv) begin
            lo_q <= lo_q + 8'h01;
            if (direct || (lo_q == 8'hFF)) begin
                hi_q <= hi_q + 8'h01;
            end
        end
    end

    // Write path strobes, only byte lane 0 carries data
    assign wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wbyte   = wdata_q[7:0];
    assign wr_ctrl = wr_go & wstrb_q[0] & (awaddr_q == reg_addr(`BITM_IDX_CTRL));
    assign wr_src  = wr_go & wstrb_q[0] & (awaddr_q == reg_addr(`BITM_IDX_SRC));
    assign wr_stat = wr_go & wstrb_q[0] & (awaddr_q == reg_addr(`BITM_IDX_STAT));
    assign wr_mask = wr_go & wstrb_q[0] & (awaddr_q == reg_addr(`BITM_IDX_MASK));

    // Write address channel, held until write done
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_have_q     <= 1'b0;
            awaddr_q      <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_go) begin
            aw_have_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, taken in any order to address
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            w_have_q     <= 1'b0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_go) begin
            w_have_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response, decode error on unmapped address
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BITM_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(awaddr_q) ? `BITM_RESP_OKAY : `BITM_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register; flags stored as written, events set them
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= bitm_ctrl_type'(`BITM_RST_CTRL);
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bitm_ctrl_type'(wbyte);
            end
            // flags only fall by software write
            // interval one flag set, set wins
            if (evt.int1) begin
                ctrl_q.interval1_flag <= 1'b1;
            end
            // interval zero flag set, set wins
            if (evt.int0) begin
                ctrl_q.interval0_flag <= 1'b1;
            end
        end
    end

    // Source select and interrupt mask
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_q  <= BITM_SRC_OSC;
            mask_q <= `BITM_RST_MASK;
        end else begin
            if (wr_src) begin
                src_q <= bitm_src_type'(wbyte[0]);
            end
            if (wr_mask) begin
                mask_q <= wbyte[1:0];
            end
        end
    end

    // Sticky status, write one clears, new event wins
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= `BITM_RST_STAT;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? wbyte[1:0] : 2'b00))
                    | {evt.int1, evt.int0};
        end
    end

    // Read channel, answer one cycle after address taken
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BITM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `BITM_RESP_OKAY;
            if (s_axi_araddr == reg_addr(`BITM_IDX_CTRL)) begin
                s_axi_rdata <= {24'h000000, ctrl_q};
            end else if (s_axi_araddr == reg_addr(`BITM_IDX_SRC)) begin
                s_axi_rdata <= {31'h00000000, src_q};
            end else if (s_axi_araddr == reg_addr(`BITM_IDX_STAT)) begin
                s_axi_rdata <= {30'h00000000, stat_q};
            end else if (s_axi_araddr == reg_addr(`BITM_IDX_MASK)) begin
                s_axi_rdata <= {30'h00000000, mask_q};
            end else begin
                // Unmapped address
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `BITM_RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Registered outputs; flag outputs one cycle behind the flags, watchdog pulse one cycle behind its event
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o          <= 1'b0;
            vec_irq_o      <= 1'b0;
            hold_release_o <= 1'b0;
            wdt_tick_o     <= 1'b0;
        end else begin
            irq_o          <= |(stat_q & mask_q);
            vec_irq_o      <= (ctrl_q.ie1 & ctrl_q.interval1_flag) | (ctrl_q.ie0 & ctrl_q.interval0_flag);
            hold_release_o <= (ctrl_q.ie1 & ctrl_q.interval1_flag) | (ctrl_q.ie0 & ctrl_q.interval0_flag);
            wdt_tick_o     <= evt.wdt;
        end
    end

endmodule

// *** bitm_timer_chk.sv ***
`timescale 1ns/1ps

module bitm_timer_chk
    import bitm_pkg::*;
#(
    parameter int AW = 18                   // Address width
) (
    input wire logic        sys_clk_i,      // Clock
    input wire logic        rst_i,          // Reset
    input wire logic        s_axi_awvalid,  // AW valid
    input wire logic        s_axi_awready,  // AW ready
    input wire logic        s_axi_wvalid,   // W valid
    input wire logic        s_axi_wready,   // W ready
    input wire logic [1:0]  s_axi_bresp,    // B code
    input wire logic        s_axi_bvalid,   // B valid
    input wire logic        s_axi_bready,   // B ready
    input wire logic        s_axi_arvalid,  // AR valid
    input wire logic        s_axi_arready,  // AR ready
    input wire logic [31:0] s_axi_rdata,    // R data
    input wire logic        s_axi_rvalid,   // R valid
    input wire logic        s_axi_rready,   // R ready
    input wire logic        vec_irq_o,      // Request
    input wire logic        hold_release_o, // Release
    input wire logic        wdt_tick_o      // Watchdog pulse
);
    // One domain, reset silences everything
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Both write channels taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // Response appears on the second edge after
    sequence s_wr_resp;
        ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_hold_vec: assert property (hold_release_o == vec_irq_o)
        else $error("hold release differs from interval request");
    a_write_answer: assert property (s_wr_take |-> s_wr_resp)
        else $error("write response not two cycles after take");
    a_aw_blocked: assert property (s_wr_take |=> (!s_axi_awready && !s_axi_wready) [*2])
        else $error("second write accepted before response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after take");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before handshake");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before handshake");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_wdt_gap: assert property (wdt_tick_o |=> !wdt_tick_o [*8])
        else $error("watchdog pulses too close");
endmodule

bind bitm_timer bitm_timer_chk #(.AW(AW)) u_chk (
    .sys_clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .vec_irq_o, .hold_release_o, .wdt_tick_o
);

// *** tb_base_interval_timer.sv ***
`timescale 1ns/1ps
`include "bitm_params.svh"

module tb_base_interval_timer
    import bitm_pkg::*;
;
    localparam int DIV  = 2;      // Short divider keeps runs brief
    localparam int OSC  = 6;      // Oscillator period in clocks
    localparam int CEIL = 95000;  // Hang limit in clocks

    logic        sys_clk_i, rst_i, osc_i;                  // Clock, reset, oscillator
    logic [1:0]  osc_ph;                                   // Oscillator phase
    logic [17:0] s_axi_awaddr, s_axi_araddr;               // Addresses
    logic [31:0] s_axi_wdata, s_axi_rdata;                 // Data
    logic [1:0]  s_axi_bresp, s_axi_rresp;                 // Response codes
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;  // Write request
    logic        s_axi_bvalid, s_axi_bready;               // Write response
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;  // Read
    logic        irq_o, vec_irq_o, hold_release_o, wdt_tick_o;             // Outputs
    logic [1:0]  rsp;                                      // Last code
    logic [31:0] rd;                                       // Last read data
    int          n_mismatch, num_checks, cyc;              // Counters
    logic [7:0]  t_ctl [0:12] = '{8'h44, 8'h54, 8'h64, 8'h74, 8'hF4, 8'h41, 8'hC1, 8'hD1,
                                  8'h44, 8'h40, 8'hC0, 8'hD0, 8'hE0};  // Control per case
    int          t_tk [0:12] = '{32, 128, 512, 2048, 2048, 16384, 64, 64, 32, 8192, 32, 32,
                                 8192};                    // Base ticks per case

    bitm_timer #(.AW(18), .SYS_DIV(8'(DIV))) dut (
        .sys_clk_i, .rst_i, .osc_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o, .vec_irq_o,
        .hold_release_o, .wdt_tick_o
    );

    // Clock, 50 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Oscillator toggles every third clock, unrelated to the bus
    always @(posedge sys_clk_i) begin
        osc_ph <= (osc_ph == 2'h2) ? 2'h0 : osc_ph + 2'h1;
        if (osc_ph == 2'h2) osc_i <= ~osc_i;
    end

    // Hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected timeout: expected %0d seen %0d", CEIL, cyc);
            end_of_test;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // Write one register; bready stands high until bvalid is seen
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        @(posedge sys_clk_i);
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read one register; rready stands high until rvalid is seen
    task automatic rd_reg(input logic [15:0] idx);
        @(posedge sys_clk_i);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rsp = s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rst_dut;
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask

    // Count from a fresh start until the first event; the window covers sync latency
    task automatic meas(input logic [7:0] ctl, input logic src, input logic wd, input int exp);
        int n;
        n = 0;
        rst_dut;
        wr(`BITM_IDX_SRC, {7'h00, src});
        wr(`BITM_IDX_CTRL, ctl);
        while (((wd ? wdt_tick_o : vec_irq_o) !== 1'b1) && n < exp + 20) begin
            @(posedge sys_clk_i);
            n = n + 1;
        end
        num_checks = num_checks + 1;
        if (n < exp - 10 || n > exp + 10) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected period %h: expected %0d seen %0d", ctl, exp, n);
        end
        $display("test period %h done", ctl);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {rst_i, osc_i, osc_ph, cyc, n_mismatch, num_checks} = '0;
        rst_i = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Reset values, decode errors, halted counter
        for (int i = 0; i < 4; i++) begin
            rd_reg(16'(`BITM_IDX_CTRL + i));
            chk("reset value", 32'h0, rd);
        end
        rd_reg(16'h0000);
        chk("unmapped read", 32'h3, 32'(rsp));
        wr(16'h0000, 8'hFF);
        chk("unmapped write", 32'h3, 32'(rsp));
        // Shortest interval one code: a running counter would set its flag
        wr(`BITM_IDX_CTRL, 8'h05);
        repeat (300) @(posedge sys_clk_i);
        rd_reg(`BITM_IDX_CTRL);
        chk("halted ctrl", 32'h05, rd);
        $display("test registers done");
        // Every period code, both fast settings, both sources
        for (int i = 0; i < 13; i++) begin
            meas(t_ctl[i], i != 8, i > 8, t_tk[i] * (i == 8 ? OSC : DIV));
        end
        // Sticky flags, enables, status and mask
        rst_dut;
        wr(`BITM_IDX_SRC, 8'h01);
        wr(`BITM_IDX_CTRL, 8'h45);
        repeat (80) @(posedge sys_clk_i);
        chk("release", 32'h1, 32'(hold_release_o));
        chk("masked irq", 32'h0, 32'(irq_o));
        rd_reg(`BITM_IDX_STAT);
        chk("status", 32'h2, rd);
        rd_reg(`BITM_IDX_CTRL);
        chk("ctrl flag1", 32'h4D, rd);
        wr(`BITM_IDX_MASK, 8'h02);
        repeat (2) @(posedge sys_clk_i);
        chk("unmasked irq", 32'h1, 32'(irq_o));
        wr(`BITM_IDX_STAT, 8'h02);
        repeat (2) @(posedge sys_clk_i);
        chk("cleared irq", 32'h0, 32'(irq_o));
        wr(`BITM_IDX_CTRL, 8'h45);
        repeat (2) @(posedge sys_clk_i);
        chk("cleared request", 32'h0, 32'(vec_irq_o));
        wr(`BITM_IDX_CTRL, 8'hD1);
        repeat (200) @(posedge sys_clk_i);
        rd_reg(`BITM_IDX_CTRL);
        chk("ctrl flag0", 32'h1, 32'(rd[1]));
        chk("request 0", 32'h1, 32'(vec_irq_o));
        $display("test flags done");
        end_of_test;
    end
endmodule
